// *** bench/dpsc_properties.sv ***
// Port checker for the panel block, bound from the bench.
// Assumes one hclk domain and the shortened flash and frame counts.
`timescale 1ns/10ps
module dpsc_properties #(
    parameter [31:0] RAWP_CYC = 32'd16
) (
    input wire hclk,
    input wire hresetn,
    input wire buf_overflow,
    input wire nav_decoded,
    input wire host_rx_char,
    input wire scan_good,
    input wire scan_skipped,
    input wire carrier_det,
    input wire smp_arm_ack,
    input wire smp_fire_ack,
    input wire led_overflow_q,
    input wire led_nav_q,
    input wire led_rx_q,
    input wire led_data_q,
    input wire led_error_q,
    input wire led_type_a_q,
    input wire led_type_b_q,
    input wire led_arm_q,
    input wire led_fire_q,
    input wire led_carrier_q,
    input wire input_halt_q,
    input wire rawp_send_q
);
    logic [31:0] gap_q;
    logic        seen_q;
    // ----------------------------------------------------------------
    // Frame spacing, counted since the period is a parameter
    // ----------------------------------------------------------------
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gap_q  <= 32'h0;
            seen_q <= 1'b0;
        end else begin
            gap_q  <= rawp_send_q ? 32'h1 : gap_q + 32'h1;
            seen_q <= seen_q | rawp_send_q;
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    chk_ovf_set: assert property (buf_overflow |=> led_overflow_q)
        else $error("overflow lamp did not light");
    chk_ovf_latch: assert property ($fell(led_overflow_q) |-> ##[0:1] input_halt_q)
        else $error("overflow lamp cleared without reset");
    chk_nav_flash: assert property (nav_decoded |=> led_nav_q [*8])
        else $error("nav lamp flash too short");
    chk_rx_flash: assert property (host_rx_char |=> led_rx_q)
        else $error("receive lamp did not flash");
    chk_data_follow: assert property (1'b1 |=> led_data_q == $past(scan_good))
        else $error("data lamp does not follow scans");
    chk_err_flash: assert property (scan_skipped |=> led_error_q [*8])
        else $error("error lamp flash too short");
    chk_type_excl: assert property (!(led_type_a_q && led_type_b_q))
        else $error("both type lamps lit");
    chk_arm_ack: assert property (smp_arm_ack |=> led_arm_q)
        else $error("arm lamp missed confirmation");
    chk_fire_ack: assert property (smp_fire_ack |-> ##2 led_fire_q)
        else $error("fire lamp missed confirmation");
    chk_carrier_on: assert property ($rose(carrier_det) |-> ##[1:6] led_carrier_q)
        else $error("carrier lamp late");
    chk_rawp_period: assert property (seen_q |->
        gap_q <= RAWP_CYC && (!rawp_send_q || gap_q == RAWP_CYC))
        else $error("raw pressure frame spacing wrong");
    cover property (smp_fire_ack ##2 led_fire_q);
    cover property (led_overflow_q ##1 !led_overflow_q);
    cover property (led_arm_q && led_type_b_q);
endmodule // dpsc_properties

// *** bench/dpsc_sampler_model.sv ***
// Water sampler reached over the modem link: confirms each command.
// Assumes one-cycle command pulses on hclk; lat sets the answer delay.
`timescale 1ns/10ps
module dpsc_sampler_model (
    input  wire       hclk,
    input  wire       hresetn,
    input  wire [7:0] lat,
    input  wire       smp_arm_cmd_q,
    input  wire       smp_fire_cmd_q,
    output logic      smp_arm_ack,
    output logic      smp_fire_ack
);
    logic [7:0] arm_cnt_q;
    logic [7:0] fire_cnt_q;
    // A long lat stands in for the slow powered-rosette start
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            arm_cnt_q    <= 8'h00;
            fire_cnt_q   <= 8'h00;
            smp_arm_ack  <= 1'b0;
            smp_fire_ack <= 1'b0;
        end else begin
            smp_arm_ack  <= (arm_cnt_q == 8'h01);
            smp_fire_ack <= (fire_cnt_q == 8'h01);
            arm_cnt_q    <= smp_arm_cmd_q ? lat : arm_cnt_q - (arm_cnt_q != 8'h00);
            fire_cnt_q   <= smp_fire_cmd_q ? lat : fire_cnt_q - (fire_cnt_q != 8'h00);
        end
    end
endmodule // dpsc_sampler_model

// *** bench/dpsc_top_tb.sv ***
// Self-checking bench for the panel block: AHB-Lite tasks and pin stimulus.
// Assumes the sampler model answers commands; counts shortened by parameters.
`timescale 1ns/10ps
`include "dpsc_defines.vh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin errors++; $display("[ERR] %s exp %h got %h", n, e, g); end end
`define WAITHI(s) for (k = 0; k < 300 && (s) !== 1'b1; k++) @(posedge hclk);
module dpsc_top_tb;
    logic hclk, hresetn, hsel, hwrite, src_switch, carrier_det, buf_overflow, scan_good, chan_we;
    logic [7:0] haddr, lat;
    logic [1:0] htrans;
    logic [2:0] btn, chan_idx;
    logic [3:0] evt, sampler_type_switch;
    logic [31:0] hwdata, chan_data, rd;
    logic [15:0] buf_level;
    wire hreadyout, hresp, led_overflow_q, led_nav_q, led_rx_q, led_tx_q, led_data_q, led_error_q;
    wire led_type_a_q, led_type_b_q, led_arm_q, led_fire_q, led_carrier_q, smp_arm_cmd_q;
    wire smp_fire_cmd_q, smp_power_q, buf_flush_q, input_halt_q, src_tape_q, recorder_en_q;
    wire rawp_send_q, smp_arm_ack, smp_fire_ack;
    wire [1:0] smp_home_ofs_q;
    wire [31:0] hrdata, display_word_q;
    wire nav_decoded = evt[0], host_rx_char = evt[1], host_tx_char = evt[2], scan_skipped = evt[3];
    wire btn_reset = btn[0], btn_arm = btn[1], btn_fire = btn[2];
    wire [3:0] lamps = {led_error_q, led_tx_q, led_rx_q, led_nav_q};
    int errors, check_count, k, i, t, n, fire_cmds, rawp_n;
    logic flush_seen;
    dpsc_top #(.FLASH_CYC(32'd8), .SWFIRE_CYC(32'd40), .RAWP_CYC(32'd16)) DUT (
        .hready(hreadyout), .hsize(3'h2), .*);
    dpsc_sampler_model u_smp (.*);
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    // Counted by non-blocking update so a snapshot taken at an edge is race free
    always @(posedge hclk) begin
        fire_cmds <= fire_cmds + (smp_fire_cmd_q === 1'b1);
        rawp_n    <= rawp_n + (rawp_send_q === 1'b1);
        if (buf_flush_q === 1'b1) flush_seen <= 1'b1;
    end
    // ----------------------------------------------------------------
    // Bus and pin tasks
    // ----------------------------------------------------------------
    task ahb(input [7:0] a, input logic w, input [31:0] wd);
        hsel <= 1'b1; haddr <= a; hwrite <= w; htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0; hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    // Held longer than the synchroniser so one press gives one edge
    task press(input int b);
        btn[b] <= 1'b1;
        repeat (8) @(posedge hclk);
        btn[b] <= 1'b0;
        repeat (8) @(posedge hclk);
    endtask
    task results;
        if (errors == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #200000;
        errors++;
        results;
    end
    initial begin
        {hresetn, hsel, hwrite, src_switch, carrier_det, buf_overflow, scan_good, chan_we} = 0;
        {haddr, htrans, btn, chan_idx, evt, sampler_type_switch, hwdata, chan_data} = 0;
        buf_level = 16'h1234; lat = 8'h03; flush_seen = 1'b0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (3) @(posedge hclk);
        `CHK("recorder_en", 1'b1, recorder_en_q)
        ahb(8'h1C, 1'b0, 32'h0); `CHK("unmapped", 32'h0, rd) `CHK("hresp", 1'b0, hresp)
        ahb(`DPSC_A_CMD, 1'b0, 32'h0); `CHK("cmd_rd", 32'h0, rd)
        ahb(`DPSC_A_CTRL, 1'b1, 32'h1); ahb(`DPSC_A_CTRL, 1'b0, 32'h0);
        @(posedge hclk); `CHK("ctrl", 32'h1, rd) `CHK("rec_off", 1'b0, recorder_en_q)
        buf_overflow <= 1'b1; @(posedge hclk); buf_overflow <= 1'b0;
        repeat (20) @(posedge hclk); `CHK("ovf", 1'b1, led_overflow_q)
        ahb(`DPSC_A_CMD, 1'b1, 32'h1); repeat (3) @(posedge hclk);
        `CHK("ovf_host", 1'b0, led_overflow_q)
        `CHK("halt", 1'b1, input_halt_q) `CHK("flush", 1'b1, flush_seen)
        ahb(`DPSC_A_CMD, 1'b1, 32'h4); repeat (3) @(posedge hclk);
        `CHK("resume", 1'b0, input_halt_q)
        buf_overflow <= 1'b1; @(posedge hclk); buf_overflow <= 1'b0; press(0);
        `CHK("ovf_btn", 1'b0, led_overflow_q) `CHK("halt_btn", 1'b1, input_halt_q)
        for (i = 0; i < 4; i++) begin
            evt[i] <= 1'b1; @(posedge hclk); evt <= 4'h0; @(posedge hclk); #1;
            `CHK("flash_on", 1'b1, lamps[i])
            repeat (9) @(posedge hclk); #1;
            `CHK("flash_off", 1'b0, lamps[i])
        end
        scan_good <= 1'b1; carrier_det <= 1'b1; src_switch <= 1'b1;
        repeat (8) @(posedge hclk);
        `CHK("data", 1'b1, led_data_q) `CHK("carrier", 1'b1, led_carrier_q)
        `CHK("tape", 1'b1, src_tape_q)
        scan_good <= 1'b0; src_switch <= 1'b0; repeat (8) @(posedge hclk);
        `CHK("data_off", 1'b0, led_data_q) `CHK("live", 1'b0, src_tape_q)
        chan_we <= 1'b1; chan_idx <= 3'h3; chan_data <= 32'hA5A50003;
        @(posedge hclk); chan_we <= 1'b0;
        // Display word follows the selector one edge after the write lands
        ahb(`DPSC_A_DSEL, 1'b1, 32'h3); @(posedge hclk); ahb(`DPSC_A_DISPLAY, 1'b0, 32'h0);
        `CHK("disp_chan", 32'hA5A50003, rd)
        ahb(`DPSC_A_DSEL, 1'b1, 32'h8); repeat (2) @(posedge hclk);
        `CHK("disp_buf", 32'h00001234, display_word_q)
        ahb(`DPSC_A_STATUS, 1'b0, 32'h0);
        `CHK("status", 32'h00000310, rd)
        ahb(`DPSC_A_DSEL, 1'b1, 32'h9); @(posedge hclk); ahb(`DPSC_A_DISPLAY, 1'b0, 32'h0);
        `CHK("disp_diag", 32'h00000310, rd)
        n = rawp_n; repeat (160) @(posedge hclk);
        `CHK("rawp", 10, rawp_n - n)
        for (t = 0; t < 3; t++) begin
            sampler_type_switch <= {2'h2, t[1:0]}; lat <= (t == 1) ? 8'd30 : 8'd3 + t[7:0];
            repeat (8) @(posedge hclk);
            `CHK("type_a", t == 0, led_type_a_q) `CHK("type_b", t != 0, led_type_b_q)
            press(1); `WAITHI(led_arm_q)
            `CHK("arm", 1'b1, led_arm_q)
            if (t == 1) `CHK("power", 1'b1, smp_power_q)
            if (t == 2) `CHK("home_ofs", 2'h2, smp_home_ofs_q)
            press(2); `WAITHI(led_fire_q)
            `CHK("fire", 1'b1, led_fire_q) `CHK("arm_off", 1'b0, led_arm_q)
            if (t == 1) begin
                n = fire_cmds; press(2);
                `CHK("fire_gate", n, fire_cmds)
                `CHK("fire_held", 1'b1, led_fire_q)
            end
            press(1); `WAITHI(led_arm_q)
            `CHK("fire_clr", 1'b0, led_fire_q)
            ahb(`DPSC_A_CMD, 1'b1, 32'h2); `WAITHI(led_fire_q)
            `CHK("sw_fire", 1'b1, led_fire_q)
            repeat (50) @(posedge hclk);
            `CHK("sw_fire_end", 1'b0, led_fire_q)
        end
        results;
    end
endmodule // dpsc_top_tb
bind dpsc_top dpsc_properties #(.RAWP_CYC(RAWP_CYC)) u_chk (.hclk, .hresetn, .buf_overflow,
    .nav_decoded, .host_rx_char, .scan_good, .scan_skipped, .carrier_det, .smp_arm_ack,
    .smp_fire_ack, .led_overflow_q, .led_nav_q, .led_rx_q, .led_data_q, .led_error_q,
    .led_type_a_q, .led_type_b_q, .led_arm_q, .led_fire_q, .led_carrier_q, .input_halt_q,
    .rawp_send_q);

// *** rtl/dpsc_defines.vh ***
// Constants of the deck panel and sampler control block.
// Assumes a 100 MHz hclk and word-aligned AHB-Lite accesses.
//
// Notes on behaviour
// - Overflow lamp lights when host output buffer overflows; lost data stays lost.
// - Overflow lamp stays latched until panel reset or host reset command.
// - Navigation lamp flashes once per successfully decoded navigation sentence.
// - Receive lamp flashes on each character arriving from the host.
// - Transmit lamp flashes on each send of data to the host.
// - Data lamp stays on while scans arrive at expected rate and format.
// - Error lamp flashes when scan sequence count shows a skipped scan.
// - Type switch lights first type lamp for carousel, second for either rosette.
// - Carousel arm homes to position one; arm lamp on confirm until first fire.
// - Carousel fire closes next position; fire lamp on confirm until fire or arm.
// - Host-fired bottle lights fire lamp for five seconds after confirm, every mode.
// - First rosette arm powers sampler; arm lamp on confirm until fire press.
// - First rosette ignores fire button unless arm lamp is lit.
// - First rosette fire lamp lights on confirm, stays until arm pressed again.
// - Second rosette arm homes with switch offset; arm lamp on until first fire.
// - Second rosette fire closes next position; lamp on until fire or arm.
// - Carrier lamp follows the modem carrier detect continuously.
// - System reset empties output buffers and halts input until host instructs.
// - Source switch picks live instrument link or recorder playback.
// - Recorder output is not driven while serial uplink is configured.
// - Raw pressure frame goes out on remote output 24 times per second.
// - Display selector picks channel, buffer status or diagnostic word for display.
`ifndef DPSC_DEFINES_VH
`define DPSC_DEFINES_VH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define DPSC_CLK_HZ        100000000
`define DPSC_FLASH_MS      50
`define DPSC_FLASH_CYC     (`DPSC_FLASH_MS * (`DPSC_CLK_HZ / 1000))
`define DPSC_SWFIRE_S      5
`define DPSC_SWFIRE_CYC    (`DPSC_SWFIRE_S * `DPSC_CLK_HZ)
`define DPSC_RAWP_PER_S    24
`define DPSC_RAWP_CYC      (`DPSC_CLK_HZ / `DPSC_RAWP_PER_S)

// ----------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------
`define DPSC_A_CTRL        8'h00
`define DPSC_A_CMD         8'h04
`define DPSC_A_DSEL        8'h08
`define DPSC_A_STATUS      8'h0C
`define DPSC_A_DISPLAY     8'h10

// CTRL fields
`define DPSC_CTRL_UPLINK   0
// CMD fields, write one to act
`define DPSC_CMD_RESET     0
`define DPSC_CMD_FIRE      1
`define DPSC_CMD_RESUME    2

// Display selector codes
`define DPSC_DSEL_BUF      4'h8
`define DPSC_DSEL_DIAG     4'h9

// Sampler types on the type switch
`define DPSC_T_CAROUSEL    2'h0
`define DPSC_T_ROS_PWR     2'h1
`define DPSC_T_ROS_HOME    2'h2

`endif

// *** rtl/dpsc_stretch.v ***
// Lamp flash stretcher: holds its output for len cycles after a trigger.
// Assumes trig comes from logic on hclk.
`timescale 1ns/10ps
module dpsc_stretch (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire [31:0] len,
    input  wire        trig,
    output reg         act_q
);
    reg [31:0] cnt_q;

    // ----------------------------------------------------------------
    // Counter
    // ----------------------------------------------------------------
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= 32'h0000_0000;
            act_q <= 1'b0;
        end else if (trig) begin
            // Retrigger restarts the full length
            cnt_q <= len;
            act_q <= 1'b1;
        end else if (cnt_q > 32'h0000_0001) begin
            cnt_q <= cnt_q - 32'h0000_0001;
        end else begin
            cnt_q <= 32'h0000_0000;
            act_q <= 1'b0;
        end
    end
endmodule // dpsc_stretch

// *** rtl/dpsc_top.v ***
// Front panel lamps, sampler arm/fire sequencing and AHB-Lite registers.
// Assumes panel pins are asynchronous; event inputs and modem
// confirmations come from logic on hclk.
`timescale 1ns/10ps
`include "dpsc_defines.vh"
module dpsc_top #(
    parameter [31:0] FLASH_CYC  = `DPSC_FLASH_CYC,
    parameter [31:0] SWFIRE_CYC = `DPSC_SWFIRE_CYC,
    parameter [31:0] RAWP_CYC   = `DPSC_RAWP_CYC
) (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        hsel,
    input  wire [7:0]  haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg         hreadyout,
    output reg  [31:0] hrdata,
    output reg         hresp,
    input  wire        btn_reset,
    input  wire        btn_arm,
    input  wire        btn_fire,
    input  wire [3:0]  sampler_type_switch,
    input  wire        src_switch,
    input  wire        carrier_det,
    input  wire        buf_overflow,
    input  wire        nav_decoded,
    input  wire        host_rx_char,
    input  wire        host_tx_char,
    input  wire        scan_good,
    input  wire        scan_skipped,
    input  wire        smp_arm_ack,
    input  wire        smp_fire_ack,
    input  wire        chan_we,
    input  wire [2:0]  chan_idx,
    input  wire [31:0] chan_data,
    input  wire [15:0] buf_level,
    output reg         led_overflow_q,
    output wire        led_nav_q,
    output wire        led_rx_q,
    output wire        led_tx_q,
    output reg         led_data_q,
    output wire        led_error_q,
    output reg         led_type_a_q,
    output reg         led_type_b_q,
    output reg         led_arm_q,
    output reg         led_fire_q,
    output reg         led_carrier_q,
    output reg         smp_arm_cmd_q,
    output reg         smp_fire_cmd_q,
    output reg         smp_power_q,
    output reg  [1:0]  smp_home_ofs_q,
    output reg         buf_flush_q,
    output reg         input_halt_q,
    output reg         src_tape_q,
    output reg         recorder_en_q,
    output reg         rawp_send_q,
    output reg  [31:0] display_word_q
);
    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    // Stable value moves only when stages two and three agree,
    // which also filters single-cycle glitches on the buttons.
    localparam NPIN = 9;
    wire [NPIN-1:0] pin_raw;
    reg  [NPIN-1:0] s1_q;
    reg  [NPIN-1:0] s2_q;
    reg  [NPIN-1:0] s3_q;
    reg  [NPIN-1:0] pin_q;
    reg  [NPIN-1:0] pin_prev_q;
    wire [NPIN-1:0] pin_d;

    assign pin_raw = {carrier_det, src_switch, sampler_type_switch,
                      btn_fire, btn_arm, btn_reset};
    assign pin_d   = (s2_q & ~(s2_q ^ s3_q)) | (pin_q & (s2_q ^ s3_q));

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s1_q       <= {NPIN{1'b0}};
            s2_q       <= {NPIN{1'b0}};
            s3_q       <= {NPIN{1'b0}};
            pin_q      <= {NPIN{1'b0}};
            pin_prev_q <= {NPIN{1'b0}};
        end else begin
            s1_q       <= pin_raw;
            s2_q       <= s1_q;
            s3_q       <= s2_q;
            pin_q      <= pin_d;
            pin_prev_q <= pin_q;
        end
    end

    wire       rst_press  = pin_q[0] & ~pin_prev_q[0];
    wire       arm_press  = pin_q[1] & ~pin_prev_q[1];
    wire       fire_press = pin_q[2] & ~pin_prev_q[2];
    wire [1:0] smp_type   = pin_q[4:3];
    wire [1:0] home_ofs   = pin_q[6:5];

    // ----------------------------------------------------------------
    // AHB-Lite slave
    // ----------------------------------------------------------------
    reg        uplink_q;
    reg [3:0]  dsel_q;
    reg        wr_pend_q;
    reg [7:0]  wr_addr_q;
    reg        host_reset_q;
    reg        host_fire_q;
    reg        host_resume_q;
    reg [31:0] chan_mem [0:7];
    reg [31:0] rd_d;

    wire take   = hsel & hready & htrans[1];
    wire wr_cmd = wr_pend_q & (wr_addr_q == `DPSC_A_CMD);

    function [31:0] status_word;
        input [10:0] bits;
        begin
            status_word = {21'h000000, bits};
        end
    endfunction

    wire [31:0] stat_w = status_word({src_tape_q, input_halt_q, led_carrier_q,
                                      led_fire_q, led_arm_q, led_type_b_q,
                                      led_type_a_q, led_error_q, led_data_q,
                                      smp_power_q, led_overflow_q});

    always @* begin
        case (haddr)
            `DPSC_A_CTRL:    rd_d = {31'h00000000, uplink_q};
            `DPSC_A_DSEL:    rd_d = {28'h0000000, dsel_q};
            `DPSC_A_STATUS:  rd_d = stat_w;
            `DPSC_A_DISPLAY: rd_d = display_word_q;
            default:         rd_d = 32'h0000_0000;
        endcase
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout     <= 1'b1;
            hresp         <= 1'b0;
            hrdata        <= 32'h0000_0000;
            wr_pend_q     <= 1'b0;
            wr_addr_q     <= 8'h00;
            uplink_q      <= 1'b0;
            dsel_q        <= 4'h0;
            host_reset_q  <= 1'b0;
            host_fire_q   <= 1'b0;
            host_resume_q <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            wr_pend_q <= take & hwrite;
            wr_addr_q <= haddr;
            if (take & ~hwrite) begin
                hrdata <= rd_d;
            end
            if (wr_pend_q && wr_addr_q == `DPSC_A_CTRL) begin
                uplink_q <= hwdata[`DPSC_CTRL_UPLINK];
            end
            if (wr_pend_q && wr_addr_q == `DPSC_A_DSEL) begin
                dsel_q <= hwdata[3:0];
            end
            host_reset_q  <= wr_cmd & hwdata[`DPSC_CMD_RESET];
            host_fire_q   <= wr_cmd & hwdata[`DPSC_CMD_FIRE];
            host_resume_q <= wr_cmd & hwdata[`DPSC_CMD_RESUME];
        end
    end

    // ----------------------------------------------------------------
    // Channel words and display
    // ----------------------------------------------------------------
    always @(posedge hclk) begin
        if (chan_we) begin
            chan_mem[chan_idx] <= chan_data;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            display_word_q <= 32'h0000_0000;
        end else begin
            case (dsel_q)
                `DPSC_DSEL_BUF:  display_word_q <= {16'h0000, buf_level};
                `DPSC_DSEL_DIAG: display_word_q <= stat_w;
                default: begin
                    if (dsel_q[3]) begin
                        display_word_q <= 32'h0000_0000;
                    end else begin
                        display_word_q <= chan_mem[dsel_q[2:0]];
                    end
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Lamp flashes
    // ----------------------------------------------------------------
    dpsc_stretch u_nav (
        .hclk    (hclk),
        .hresetn (hresetn),
        .len     (FLASH_CYC),
        .trig    (nav_decoded),
        .act_q   (led_nav_q)
    );
    dpsc_stretch u_rx (
        .hclk    (hclk),
        .hresetn (hresetn),
        .len     (FLASH_CYC),
        .trig    (host_rx_char),
        .act_q   (led_rx_q)
    );
    dpsc_stretch u_tx (
        .hclk    (hclk),
        .hresetn (hresetn),
        .len     (FLASH_CYC),
        .trig    (host_tx_char),
        .act_q   (led_tx_q)
    );
    dpsc_stretch u_err (
        .hclk    (hclk),
        .hresetn (hresetn),
        .len     (FLASH_CYC),
        .trig    (scan_skipped),
        .act_q   (led_error_q)
    );

    // ----------------------------------------------------------------
    // System reset, overflow, steady lamps
    // ----------------------------------------------------------------
    wire sys_reset = rst_press | host_reset_q;
    reg  [31:0] rawp_cnt_q;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            led_overflow_q <= 1'b0;
            buf_flush_q    <= 1'b0;
            input_halt_q   <= 1'b0;
            led_data_q     <= 1'b0;
            led_carrier_q  <= 1'b0;
            led_type_a_q   <= 1'b0;
            led_type_b_q   <= 1'b0;
            src_tape_q     <= 1'b0;
            recorder_en_q  <= 1'b0;
            rawp_cnt_q     <= 32'h0000_0000;
            rawp_send_q    <= 1'b0;
        end else begin
            // Set wins over a reset in the same cycle
            if (buf_overflow) begin
                led_overflow_q <= 1'b1;
            end else if (sys_reset) begin
                led_overflow_q <= 1'b0;
            end
            buf_flush_q <= sys_reset;
            if (sys_reset) begin
                input_halt_q <= 1'b1;
            end else if (host_resume_q) begin
                input_halt_q <= 1'b0;
            end
            led_data_q    <= scan_good;
            led_carrier_q <= pin_q[8];
            led_type_a_q  <= (smp_type == `DPSC_T_CAROUSEL);
            led_type_b_q  <= (smp_type == `DPSC_T_ROS_PWR) |
                             (smp_type == `DPSC_T_ROS_HOME);
            src_tape_q    <= pin_q[7];
            recorder_en_q <= ~uplink_q;
            // Free-running frame timer; the period rounds down
            if (rawp_cnt_q >= RAWP_CYC - 32'h0000_0001) begin
                rawp_cnt_q  <= 32'h0000_0000;
                rawp_send_q <= 1'b1;
            end else begin
                rawp_cnt_q  <= rawp_cnt_q + 32'h0000_0001;
                rawp_send_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Sampler arm and fire
    // ----------------------------------------------------------------
    reg        fire_latch_q;
    reg        host_pend_q;
    reg [31:0] swfire_cnt_q;

    wire ros_pwr   = (smp_type == `DPSC_T_ROS_PWR);
    // Fire button is dead in the powered rosette until armed
    wire fire_ok   = fire_press & (~ros_pwr | led_arm_q);
    wire fire_host = host_fire_q;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            smp_arm_cmd_q  <= 1'b0;
            smp_fire_cmd_q <= 1'b0;
            smp_power_q    <= 1'b0;
            smp_home_ofs_q <= 2'h0;
            led_arm_q      <= 1'b0;
            fire_latch_q   <= 1'b0;
            host_pend_q    <= 1'b0;
            swfire_cnt_q   <= 32'h0000_0000;
            led_fire_q     <= 1'b0;
        end else begin
            smp_arm_cmd_q  <= arm_press;
            smp_fire_cmd_q <= fire_ok | fire_host;
            smp_home_ofs_q <= home_ofs;
            if (arm_press & ros_pwr) begin
                smp_power_q <= 1'b1;
            end else if (smp_fire_ack | ~ros_pwr) begin
                smp_power_q <= 1'b0;
            end
            // Arm lamp: confirmation sets, firing clears; set wins
            if (smp_arm_ack) begin
                led_arm_q <= 1'b1;
            end else if (ros_pwr & fire_ok) begin
                led_arm_q <= 1'b0;
            end else if (~ros_pwr & smp_fire_ack) begin
                led_arm_q <= 1'b0;
            end
            // Host fires bypass the latch and use the long timer
            if (fire_host) begin
                host_pend_q <= 1'b1;
            end else if (smp_fire_ack) begin
                host_pend_q <= 1'b0;
            end
            if (smp_fire_ack & ~host_pend_q) begin
                fire_latch_q <= 1'b1;
            end else if (arm_press) begin
                fire_latch_q <= 1'b0;
            end else if (fire_ok & ~ros_pwr) begin
                fire_latch_q <= 1'b0;
            end
            if (smp_fire_ack & host_pend_q) begin
                swfire_cnt_q <= SWFIRE_CYC;
            end else if (swfire_cnt_q != 32'h0000_0000) begin
                swfire_cnt_q <= swfire_cnt_q - 32'h0000_0001;
            end
            led_fire_q <= fire_latch_q | (swfire_cnt_q != 32'h0000_0000);
        end
    end
endmodule // dpsc_top
